// File: rtl/pcrc_defines.svh
`ifndef PCRC_DEFINES_SVH
`define PCRC_DEFINES_SVH
// ----------------------------------------
// configuration offsets
// ----------------------------------------
`define PCRC_OFF_SUBSYS      8'h2c
`define PCRC_OFF_ROMBASE     8'h30
`define PCRC_OFF_FIRST_CAP   8'h34
`define PCRC_OFF_RSVD38      8'h38
`define PCRC_OFF_SUBSYS_WR   8'h40
// ----------------------------------------
// field positions
// ----------------------------------------
`define PCRC_ROM_BASE_MSB    31
`define PCRC_ROM_BASE_LSB    22
`define PCRC_ROM_EN_BIT      0
`define PCRC_ROM_IMAGE_BITS  16
// ----------------------------------------
// rom byte locations of the maker code
// ----------------------------------------
`define PCRC_ROM_MAKER_LO    8'h54
`define PCRC_ROM_MAKER_CNT   4
// ----------------------------------------
// capability pointer values
// ----------------------------------------
`define PCRC_CAP_PCI         8'h00
`define PCRC_CAP_AGP         8'h44
`define PCRC_CAP_ACPI        8'h60
// ----------------------------------------
// reset values
// ----------------------------------------
`define PCRC_RST_ID          32'h0000_0000
`define PCRC_RST_ROMBASE     10'h000
`endif

// File: rtl/pcrc_pkg.sv
package pcrc_pkg;
	typedef enum logic [1:0] {
		PCRC_LD_IDLE,
		PCRC_LD_FETCH,
		PCRC_LD_DONE
	} pcrc_ld_state_t;
	typedef logic [7:0] pcrc_byte_t;
endpackage

// File: rtl/pcrc_byte_lane.sv
`include "pcrc_defines.svh"
module pcrc_byte_lane
	import pcrc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// update sources
	input  wire logic        cfg_we,
	input  wire logic [7:0]  cfg_data,
	input  wire logic        rom_we,
	input  wire logic [7:0]  rom_data,
	// stored byte
	output logic      [7:0]  lane_q
);
	logic [7:0] lane_d;
	// rom load happens only during reset fetch, so no real conflict; rom wins anyway
	assign lane_d = rom_we ? rom_data : (cfg_we ? cfg_data : lane_q);
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			lane_q <= 8'h00;
		end else begin
			lane_q <= lane_d;
		end
	end
endmodule

// File: rtl/pcrc_rom_loader.sv
`include "pcrc_defines.svh"
module pcrc_rom_loader
	import pcrc_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// strap captured at reset
	input  wire logic        load_from_rom,
	// rom read port
	output logic      [7:0]  rom_addr,
	output logic             rom_rd,
	input  wire logic [7:0]  rom_rdata,
	input  wire logic        rom_ack,
	// byte write toward the id word
	output logic      [3:0]  byte_we,
	output logic      [7:0]  byte_data,
	output logic             load_done
);
	pcrc_ld_state_t state_q;
	pcrc_ld_state_t state_d;
	logic [1:0]     idx_q;
	logic [1:0]     idx_d;
	logic           last_w;
	assign last_w    = (idx_q == 2'h3);
	assign rom_addr  = `PCRC_ROM_MAKER_LO + {6'h00, idx_q};
	assign rom_rd    = (state_q == PCRC_LD_FETCH);
	assign byte_data = rom_rdata;
	assign load_done = (state_q == PCRC_LD_DONE);
	// sub-vendor bytes 0x54..0x57 land in the four lanes of the id word
	assign byte_we   = (rom_rd && rom_ack) ? (4'h1 << idx_q) : 4'h0; // RULE3
	always_comb begin
		state_d = state_q;
		idx_d   = idx_q;
		case (state_q)
			PCRC_LD_IDLE: begin
				// stay idle until the captured strap asks for a fetch; leaving early would skip the load
				state_d = load_from_rom ? PCRC_LD_FETCH : PCRC_LD_IDLE; // RULE2
			end
			PCRC_LD_FETCH: begin
				if (rom_ack) begin
					idx_d = idx_q + 2'h1;
					if (last_w) begin
						state_d = PCRC_LD_DONE;
					end
				end
			end
			PCRC_LD_DONE: begin
				state_d = PCRC_LD_DONE;
			end
			default: begin
				state_d = PCRC_LD_IDLE;
			end
		endcase
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= PCRC_LD_IDLE;
			idx_q   <= 2'h0;
		end else begin
			state_q <= state_d;
			idx_q   <= idx_d;
		end
	end
endmodule

// File: rtl/pcrc_regs.sv
// Overview of operation
// RULE1: the upper half of the id word is a product code that writes at 0x2c cannot change.
// RULE2: a strap caught at reset chooses whether the maker code comes from rom or from software.
// RULE3: when strapped for rom, the four id bytes are fetched from rom bytes 0x54 to 0x57 after reset.
// RULE4: otherwise software writes the id bytes at 0x40 to 0x43 and the word at 0x2c shows them.
// RULE5: rom base bits 31 to 22 are writable, giving a 4 MByte aligned window.
// RULE6: rom base bits 21 to 11 read zero and ignore writes.
// RULE7: the 64 KByte bios image sits at the bottom of the window.
// RULE8: the rom enable bit resets to zero and accesses are claimed only with it and memory enable set.
// RULE9: the capability pointer reads 0x00 for pci, 0x44 for agp and 0x60 with acpi, and is read only.
// RULE10: the word at 0x38 reads zero and discards writes.
// RULE11: the writable id at 0x40 aliases the read-only id at 0x2c.
// RULE12: rom base bits 10 to 1 and capability word bits 31 to 8 read zero.
`include "pcrc_defines.svh"
module pcrc_regs
	import pcrc_pkg::*;
#(
	parameter int ROM_IMAGE_BITS = `PCRC_ROM_IMAGE_BITS
)
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	// power-on straps
	input  wire logic        strap_id_from_rom,
	input  wire logic        strap_host_agp,
	input  wire logic        strap_acpi,
	// configuration access
	input  wire logic        cfg_sel,
	input  wire logic        cfg_wr,
	input  wire logic [7:0]  cfg_addr,
	input  wire logic [3:0]  cfg_be,
	input  wire logic [31:0] cfg_wdata,
	output logic      [31:0] cfg_rdata,
	output logic             cfg_hit,
	// command register memory enable
	input  wire logic        mem_space_en,
	// host memory access to rom window
	input  wire logic        mem_req,
	input  wire logic [31:0] mem_addr,
	output logic             rom_claim,
	output logic      [15:0] rom_image_offset,
	// attached rom read port
	output logic      [7:0]  rom_addr,
	output logic             rom_rd,
	input  wire logic [7:0]  rom_rdata,
	input  wire logic        rom_ack,
	// status
	output logic             id_load_done
);
	// ----------------------------------------
	// parameter check
	// ----------------------------------------
	initial begin
		if (ROM_IMAGE_BITS < 1 || ROM_IMAGE_BITS > $bits(rom_image_offset)) begin
			$error("rom image must fit the window and the offset port");
		end
	end
	// ----------------------------------------
	// strap capture after reset release
	// ----------------------------------------
	logic       strap_taken_q;
	logic       from_rom_q;
	logic       agp_q;
	logic       acpi_q;
	// straps are sampled once on the first edge after release, never inside reset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_taken_q <= 1'b0;
			from_rom_q    <= 1'b0;
			agp_q         <= 1'b0;
			acpi_q        <= 1'b0;
		end else if (!strap_taken_q) begin
			strap_taken_q <= 1'b1;
			from_rom_q    <= strap_id_from_rom; // RULE2
			agp_q         <= strap_host_agp;
			acpi_q        <= strap_acpi;
		end
	end
	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire sel_subsys    = cfg_sel && (cfg_addr == `PCRC_OFF_SUBSYS);
	wire sel_rombase   = cfg_sel && (cfg_addr == `PCRC_OFF_ROMBASE);
	wire sel_first_cap = cfg_sel && (cfg_addr == `PCRC_OFF_FIRST_CAP);
	wire sel_rsvd38    = cfg_sel && (cfg_addr == `PCRC_OFF_RSVD38);
	wire sel_subsys_wr = cfg_sel && (cfg_addr == `PCRC_OFF_SUBSYS_WR);
	assign cfg_hit = sel_subsys || sel_rombase || sel_first_cap || sel_rsvd38 || sel_subsys_wr;
	// ----------------------------------------
	// identification word
	// ----------------------------------------
	logic        loader_kick;
	logic [3:0]  rom_byte_we;
	logic [7:0]  rom_byte_data;
	logic [31:0] id_word;
	logic [3:0]  cfg_id_we;
	// the loader idles until the strap is held; in software mode it never leaves idle
	assign loader_kick = strap_taken_q && from_rom_q;
	// writes at 0x2c are ignored; only the alias at 0x40 and the rom loader change the word
	// software writes are honoured in either strap mode so bios can patch later
	assign cfg_id_we = (sel_subsys_wr && cfg_wr) ? cfg_be : 4'h0; // RULE1 RULE4 RULE11
	pcrc_rom_loader u_loader (
		.sys_clk       (sys_clk),
		.rst_b         (rst_b),
		.load_from_rom (loader_kick),
		.rom_addr      (rom_addr),
		.rom_rd        (rom_rd),
		.rom_rdata     (rom_rdata),
		.rom_ack       (rom_ack),
		.byte_we       (rom_byte_we),
		.byte_data     (rom_byte_data),
		.load_done     ()
	);
	logic       ld_seen_q;
	// done when rom_byte_we[3] writes the last rom byte; from_rom_q low after strap capture means software mode
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ld_seen_q <= 1'b0;
		end else if (strap_taken_q && (!from_rom_q || rom_byte_we[3])) begin
			ld_seen_q <= 1'b1;
		end
	end
	assign id_load_done = ld_seen_q;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			pcrc_byte_lane u_lane (
				.sys_clk  (sys_clk),
				.rst_b    (rst_b),
				.cfg_we   (cfg_id_we[g]),
				.cfg_data (cfg_wdata[g*8 +: 8]),
				.rom_we   (rom_byte_we[g]),
				.rom_data (rom_byte_data),
				.lane_q   (id_word[g*8 +: 8])
			); // RULE3 RULE11
		end
	endgenerate
	// ----------------------------------------
	// expansion rom base
	// ----------------------------------------
	localparam int BASE_W = `PCRC_ROM_BASE_MSB - `PCRC_ROM_BASE_LSB + 1;
	logic [BASE_W-1:0] rom_base_q;
	logic [BASE_W-1:0] rom_base_d;
	logic              rom_en_q;
	logic              rom_en_d;
	wire               wr_rombase = sel_rombase && cfg_wr;
	wire [31:0]        base_merge = {
		cfg_be[3] ? cfg_wdata[31:24] : {rom_base_q[BASE_W-1:2]},
		cfg_be[2] ? cfg_wdata[23:22] : rom_base_q[1:0],
		22'h000000
	};
	assign rom_base_d = wr_rombase ? base_merge[`PCRC_ROM_BASE_MSB:`PCRC_ROM_BASE_LSB] : rom_base_q; // RULE5
	assign rom_en_d   = (wr_rombase && cfg_be[0]) ? cfg_wdata[`PCRC_ROM_EN_BIT] : rom_en_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rom_base_q <= `PCRC_RST_ROMBASE;
			rom_en_q   <= 1'b0; // RULE8
		end else begin
			rom_base_q <= rom_base_d;
			rom_en_q   <= rom_en_d;
		end
	end
	wire [31:0] rombase_rd = {rom_base_q, 11'h000, 10'h000, rom_en_q}; // RULE6 RULE12
	// ----------------------------------------
	// rom window claim
	// ----------------------------------------
	// only the low image bits address the rom; the rest of the window is not claimed
	wire window_hit = (mem_addr[`PCRC_ROM_BASE_MSB:`PCRC_ROM_BASE_LSB] == rom_base_q);
	wire image_hit  = (mem_addr[`PCRC_ROM_BASE_LSB-1:ROM_IMAGE_BITS] == '0); // RULE7
	assign rom_claim = mem_req && rom_en_q && mem_space_en && window_hit && image_hit; // RULE8
	logic [15:0] rom_off_q;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rom_off_q <= 16'h0000;
		end else if (rom_claim) begin
			rom_off_q <= mem_addr[15:0]; // RULE7
		end
	end
	assign rom_image_offset = rom_off_q;
	// ----------------------------------------
	// capability pointer
	// ----------------------------------------
	wire [7:0] cap_sel = acpi_q ? `PCRC_CAP_ACPI : (agp_q ? `PCRC_CAP_AGP : `PCRC_CAP_PCI); // RULE9
	wire [31:0] first_cap_rd = {24'h000000, cap_sel}; // RULE12
	// ----------------------------------------
	// read mux
	// ----------------------------------------
	// reads are registered; unmapped offsets and the 0x38 word read zero
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	assign rdata_d = sel_subsys    ? id_word    :
	                 sel_subsys_wr ? id_word    :
	                 sel_rombase   ? rombase_rd :
	                 sel_first_cap ? first_cap_rd :
	                 32'h0000_0000; // RULE10
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= `PCRC_RST_ID;
		end else if (cfg_sel && !cfg_wr) begin
			rdata_q <= rdata_d;
		end
	end
	assign cfg_rdata = rdata_q;
endmodule

// File: dv/pcrc_regs_properties.sv
module pcrc_regs_chk
	import pcrc_pkg::*;
#(
	parameter int ROM_IMAGE_BITS = 16
)
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// straps
	input wire logic        strap_id_from_rom,
	input wire logic        strap_host_agp,
	input wire logic        strap_acpi,
	// config access
	input wire logic        cfg_sel,
	input wire logic        cfg_wr,
	input wire logic [7:0]  cfg_addr,
	input wire logic [3:0]  cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic        cfg_hit,
	// memory side
	input wire logic        mem_space_en,
	input wire logic        mem_req,
	input wire logic [31:0] mem_addr,
	input wire logic        rom_claim,
	input wire logic [15:0] rom_image_offset,
	// rom port
	input wire logic [7:0]  rom_addr,
	input wire logic        rom_rd,
	input wire logic [7:0]  rom_rdata,
	input wire logic        rom_ack,
	input wire logic        id_load_done
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic rd = cfg_sel & ~cfg_wr;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_claim_en; rom_claim |-> mem_req && mem_space_en; endproperty
	a_claim_en: assert property (p_claim_en) else $error("claim without enables");
	property p_claim_win; rom_claim |-> mem_addr[21:ROM_IMAGE_BITS] == '0; endproperty
	a_claim_win: assert property (p_claim_win) else $error("claim above image");
	property p_claim_off; rom_claim |=> rom_image_offset == $past(mem_addr[15:0]); endproperty
	a_claim_off: assert property (p_claim_off) else $error("image offset wrong");
	property p_fetch_addr; rom_rd |-> rom_addr >= 8'h54 && rom_addr <= 8'h57; endproperty
	a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address out of range");
	property p_fetch_step; rom_rd && rom_ack && rom_addr != 8'h57 |=> rom_rd && rom_addr == $past(rom_addr) + 8'h01;
	endproperty
	a_fetch_step: assert property (p_fetch_step) else $error("fetch did not step");
	property p_fetch_end; rom_rd && rom_ack && rom_addr == 8'h57 |=> !rom_rd ##[0:1] id_load_done; endproperty
	a_fetch_end: assert property (p_fetch_end) else $error("fetch did not finish");
	property p_sw_mode; !strap_id_from_rom |-> !rom_rd; endproperty
	a_sw_mode: assert property (p_sw_mode) else $error("fetch in software mode");
	property p_rsvd; rd && cfg_addr == 8'h38 |=> cfg_rdata == 32'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved word not zero");
	// straps only change inside reset, so live values match the captured ones
	property p_cap; rd && cfg_addr == 8'h34 |=> cfg_rdata == {24'h0, strap_acpi ? 8'h60 : strap_host_agp ? 8'h44 : 8'h00};
	endproperty
	a_cap: assert property (p_cap) else $error("capability pointer wrong");
	property p_rom_low; rd && cfg_addr == 8'h30 |=> cfg_rdata[21:1] == 21'h0; endproperty
	a_rom_low: assert property (p_rom_low) else $error("rom base low bits set");
	c_fetch: cover property (rom_rd && rom_ack && rom_addr == 8'h57);
	c_claim: cover property (rom_claim);
	c_cap: cover property (rd && cfg_addr == 8'h34);
endmodule
bind pcrc_regs pcrc_regs_chk #(.ROM_IMAGE_BITS(ROM_IMAGE_BITS)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
	.strap_id_from_rom(strap_id_from_rom), .strap_host_agp(strap_host_agp), .strap_acpi(strap_acpi),
	.cfg_sel(cfg_sel), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
	.cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit), .mem_space_en(mem_space_en), .mem_req(mem_req),
	.mem_addr(mem_addr), .rom_claim(rom_claim), .rom_image_offset(rom_image_offset), .rom_addr(rom_addr),
	.rom_rd(rom_rd), .rom_rdata(rom_rdata), .rom_ack(rom_ack), .id_load_done(id_load_done));

// File: dv/pcrc_rom_model.sv
module pcrc_rom_model (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_b,
	// read port
	input wire logic [7:0]  rom_addr,
	input wire logic        rom_rd,
	input wire logic        slow,
	output logic     [7:0]  rom_rdata,
	output logic            rom_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic gap_q;
	// slow mode inserts one wait cycle before every byte
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) gap_q <= 1'b0;
		else gap_q <= slow & rom_rd & ~gap_q;
	end
	assign rom_ack = rom_rd & ~(slow & ~gap_q);
	// data off the bus is inverted so a stale byte cannot pass
	assign rom_rdata = rom_ack ? rom_addr ^ 8'ha5 : ~(rom_addr ^ 8'ha5);
endmodule

// File: dv/pcrc_regs_tb.sv
module pcrc_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] ROM_ID = {8'h57 ^ 8'ha5, 8'h56 ^ 8'ha5, 8'h55 ^ 8'ha5, 8'h54 ^ 8'ha5};
	logic        sys_clk = 1'b0, rst_b = 1'b0, slow = 1'b0;
	logic        strap_id_from_rom = 1'b0, strap_host_agp = 1'b0, strap_acpi = 1'b0;
	logic        cfg_sel = 1'b0, cfg_wr = 1'b0, mem_space_en = 1'b0, mem_req = 1'b0;
	logic [7:0]  cfg_addr = 8'h00, rom_addr, rom_rdata;
	logic [3:0]  cfg_be = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, mem_addr = 32'h0, cfg_rdata;
	logic [15:0] rom_image_offset;
	logic        cfg_hit, rom_claim, rom_rd, rom_ack, id_load_done;
	int          fail_count = 0, samples_checked = 0, cycles = 0;
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
	$display("unexpected %s expected %h seen %h", n, e, g); end end
	// ----------------------------------------
	// design and rom
	// ----------------------------------------
	pcrc_regs u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .strap_id_from_rom(strap_id_from_rom),
		.strap_host_agp(strap_host_agp), .strap_acpi(strap_acpi), .cfg_sel(cfg_sel), .cfg_wr(cfg_wr),
		.cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_hit(cfg_hit),
		.mem_space_en(mem_space_en), .mem_req(mem_req), .mem_addr(mem_addr), .rom_claim(rom_claim),
		.rom_image_offset(rom_image_offset), .rom_addr(rom_addr), .rom_rd(rom_rd), .rom_rdata(rom_rdata),
		.rom_ack(rom_ack), .id_load_done(id_load_done));
	pcrc_rom_model u_rom (.sys_clk(sys_clk), .rst_b(rst_b), .rom_addr(rom_addr), .rom_rd(rom_rd),
		.slow(slow), .rom_rdata(rom_rdata), .rom_ack(rom_ack));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// straps move only inside reset, since they are captured at release
	task automatic rst(input logic rom, agp, acpi, sl);
		@(negedge sys_clk);
		rst_b = 1'b0;
		{strap_id_from_rom, strap_host_agp, strap_acpi, slow} = {rom, agp, acpi, sl};
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		for (int i = 0; i < 40 && id_load_done !== 1'b1; i++) @(negedge sys_clk);
		`CHK("load", 1'b1, id_load_done)
	endtask
	task automatic acc(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d, e);
		@(negedge sys_clk);
		{cfg_sel, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, wr, a, be, d};
		#1 `CHK("hit", (a inside {8'h2c, 8'h30, 8'h34, 8'h38, 8'h40}), cfg_hit)
		@(negedge sys_clk);
		cfg_sel = 1'b0;
		if (!wr) `CHK("rdata", e, cfg_rdata)
	endtask
	task automatic mem(input logic en, input logic [31:0] a, input logic e);
		@(negedge sys_clk);
		{mem_req, mem_space_en, mem_addr} = {1'b1, en, a};
		#1 `CHK("claim", e, rom_claim)
		@(negedge sys_clk);
		mem_req = 1'b0;
		if (e) `CHK("offset", a[15:0], rom_image_offset)
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		rst(1, 1, 0, 1);
		acc(0, 8'h2c, 4'hf, 0, ROM_ID);
		acc(1, 8'h2c, 4'hf, '1, 0);
		acc(0, 8'h2c, 4'hf, 0, ROM_ID);
		acc(1, 8'h34, 4'hf, '1, 0);
		acc(0, 8'h34, 4'hf, 0, 32'h44);
		acc(1, 8'h38, 4'hf, '1, 0);
		acc(0, 8'h38, 4'hf, 0, 0);
		acc(0, 8'h30, 4'hf, 0, 0);
		mem(1, 32'h0000_1234, 0);
		acc(1, 8'h30, 4'hf, '1, 0);
		acc(0, 8'h30, 4'hf, 0, 32'hffc0_0001);
		mem(1, 32'hffc0_1234, 1);
		mem(1, 32'hffc1_0000, 0);
		mem(0, 32'hffc0_1234, 0);
		acc(0, 8'h3c, 4'hf, 0, 0);
		rst(0, 0, 0, 0);
		acc(0, 8'h34, 4'hf, 0, 0);
		acc(1, 8'h40, 4'hf, 32'h1234_5678, 0);
		acc(1, 8'h40, 4'h2, 32'hffff_abff, 0);
		acc(0, 8'h2c, 4'hf, 0, 32'h1234_ab78);
		acc(0, 8'h40, 4'hf, 0, 32'h1234_ab78);
		for (int i = 0; i < 2; i++) begin
			rst(1, i[0], 1, 0);
			acc(0, 8'h34, 4'hf, 0, 32'h60);
			acc(0, 8'h2c, 4'hf, 0, ROM_ID);
		end
		close_out();
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			close_out();
		end
	end
endmodule
